// file: ntl_pkg.sv
// Purpose: shared constants and types of the numeric telegram link
// Assumes: AXI4-Lite word registers, 125 MHz sys_clk
// Notes: all offsets are byte addresses
package ntl_pkg;
  localparam int CLK_KHZ = 125000;
  localparam int TICK_SLOW_MS = 100;
  localparam int TICK_FAST_MS = 10;
  localparam int TICK_SLOW_CYC = TICK_SLOW_MS * CLK_KHZ;
  localparam int TICK_FAST_CYC = TICK_FAST_MS * CLK_KHZ;
  localparam logic [4:0] RETRY_TICKS = 5'h1E;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FLAGS = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_TXD = 8'h10;
  localparam logic [7:0] OFS_RXD = 8'h20;
  localparam int C_RXALW = 0;
  localparam int C_TXALW = 1;
  localparam int C_FAST = 2;
  localparam int C_BCC = 3;
  localparam int C_RETRY = 4;
  localparam int C_RXN = 6;
  localparam int C_TXN = 11;
  localparam int F_RXBUSY = 0;
  localparam int F_TXBUSY = 1;
  localparam logic [15:0] CTRL_RST = 16'h0848;
  localparam logic [15:0] BAUD_RST = 16'h32DC;
  localparam logic [1:0] RETRY_REPEAT = 2'h0;
  localparam logic [1:0] RETRY_ONCE = 2'h1;
  localparam logic [1:0] RETRY_RING = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  localparam logic [7:0] CH_STX = 8'h02;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_ACK = 8'h06;
  localparam logic [7:0] CH_NAK = 8'h15;
  localparam logic [7:0] CH_CR = 8'h0D;
  localparam logic [7:0] CH_LF = 8'h0A;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [3:0] DIGIT_HI = 4'h3;
  typedef enum logic [1:0] {RX_IDLE, RX_DATA, RX_BCC} ntl_rx_t;
  typedef enum logic [1:0] {TX_IDLE, TX_TEL, TX_ACK, TX_WAIT} ntl_tx_t;
endpackage

// file: ntl_link.sv
// Purpose: numeric telegram serial link, flag buffers behind AXI4-Lite
// Assumes: 8N1 serial line, inputs synchronous to sys_clk
// Notes: acks owed while waiting for our own ack go out after the wait
// Contract
// - store only telegrams without line errors
// - check in shadow store, then copy
// - receive-always stores every good telegram
// - otherwise store only while receive busy low
// - receive busy rises on first character
// - transmit decided once per time-base tick
// - transmit-always sends every tick
// - otherwise send when transmit busy high
// - transmit busy clears at first character
// - buffer size n is 1 to 31 digits
// - receive and transmit sizes independent
// - code 01 checked, code 00 manual
// - option 0 resends every 30 ticks
// - option 1 sends once, busy stays high
// - option 3 sends once, no ack
// - fixed ASCII control character codes
// - digits get upper bits, check covers ETX
// - reply positive or negative acknowledgement
// - manual variant uses CR LF and hash
`timescale 1ns/1ps
module ntl_link #(
  parameter int TICK_SLOW = ntl_pkg::TICK_SLOW_CYC,
  parameter int TICK_FAST = ntl_pkg::TICK_FAST_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic serialRx,
  output logic serialTx
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int i = 0; i < 4; i++) begin
      if (s[i]) o[8*i +: 8] = n[8*i +: 8];
    end
    return o;
  endfunction
  function automatic logic [4:0] clampN(input logic [4:0] n);
    return (n == 5'h0) ? 5'h1 : n;
  endfunction

  // bus, configuration and flags
  logic awHave, wHave, next_awHave, next_wHave;
  logic [7:0] awAddr, next_awAddr;
  logic [31:0] wData, next_wData, next_rdata, w;
  logic [3:0] wStrb, next_wStrb;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [15:0] ctrl, next_ctrl, baud, next_baud;
  logic [127:0] txData, next_txData;
  logic rxBusy, txBusy, lock, next_rxBusy, next_txBusy, next_lock;
  logic swWr, swFlags;
  // receive side
  ntl_pkg::ntl_rx_t rxState, next_rxState;
  logic [3:0] rxBit, next_rxBit;
  logic [15:0] rxBaud, next_rxBaud;
  logic [7:0] rxSh, next_rxSh, rxBcc, next_rxBcc;
  logic [4:0] rxCnt, next_rxCnt;
  logic rxErr, rxAcc, rxSaved, hashSeen, next_rxErr, next_rxAcc, next_rxSaved, next_hashSeen;
  logic [123:0] rxShadow, rxData, next_rxShadow, next_rxData;
  logic byteEv, frameErr, stxAcc, fin, ok, store, rxSetBusy, rxRestore, ackGood, ackBad, ackReqEv;
  // transmit side
  ntl_pkg::ntl_tx_t txState, next_txState;
  logic [5:0] txPos, next_txPos;
  logic [7:0] txBcc, next_txBcc, ch;
  logic [4:0] txRetry, next_txRetry, nTx;
  logic [23:0] tickCnt, next_tickCnt;
  logic [3:0] txBit, next_txBit;
  logic [15:0] txBaud, next_txBaud;
  logic [8:0] txSh, next_txSh;
  logic ackPend, ackOk, next_ackPend, next_ackOk, next_serialTx;
  logic tick, txLoad, last, txClr, txFail;

  logic rxAlw, txAlw, bccOn;
  logic [1:0] retry;
  logic [4:0] nRx;
  assign rxAlw = ctrl[ntl_pkg::C_RXALW];
  assign txAlw = ctrl[ntl_pkg::C_TXALW];
  assign bccOn = ctrl[ntl_pkg::C_BCC];
  assign retry = ctrl[ntl_pkg::C_RETRY +: 2];
  assign nRx = clampN(ctrl[ntl_pkg::C_RXN +: 5]);
  assign nTx = clampN(ctrl[ntl_pkg::C_TXN +: 5]);

  always_comb begin
    next_awHave = awHave;
    next_wHave = wHave;
    next_awAddr = awAddr;
    next_wData = wData;
    next_wStrb = wStrb;
    next_awready = s_axi_awready;
    next_wready = s_axi_wready;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    next_arready = s_axi_arready;
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    next_ctrl = ctrl;
    next_baud = baud;
    next_txData = txData;
    w = 32'h0000_0000;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHave = 1'b1;
      next_awAddr = s_axi_awaddr;
      next_awready = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHave = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
      next_wready = 1'b0;
    end
    swWr = awHave && wHave && !s_axi_bvalid;
    swFlags = swWr && awAddr == ntl_pkg::OFS_FLAGS && wStrb[0];
    if (swWr) begin
      next_awHave = 1'b0;
      next_wHave = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = ntl_pkg::RESP_OKAY;
      if (awAddr == ntl_pkg::OFS_CTRL) begin
        w = merge({16'h0000, ctrl}, wData, wStrb);
        next_ctrl = w[15:0];
      end else if (awAddr == ntl_pkg::OFS_BAUD) begin
        w = merge({16'h0000, baud}, wData, wStrb);
        next_baud = w[15:0];
      end else if (awAddr[7:4] == ntl_pkg::OFS_TXD[7:4]) begin
        w = merge(txData[{awAddr[3:2], 5'h00} +: 32], wData, wStrb);
        next_txData[{awAddr[3:2], 5'h00} +: 32] = w;
      end else if (awAddr != ntl_pkg::OFS_FLAGS) begin
        next_bresp = ntl_pkg::RESP_DECERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = ntl_pkg::RESP_OKAY;
      next_rdata = 32'h0000_0000;
      if (s_axi_araddr == ntl_pkg::OFS_CTRL) next_rdata[15:0] = ctrl;
      else if (s_axi_araddr == ntl_pkg::OFS_FLAGS) next_rdata[1:0] = {txBusy, rxBusy};
      else if (s_axi_araddr == ntl_pkg::OFS_BAUD) next_rdata[15:0] = baud;
      else if (s_axi_araddr == ntl_pkg::OFS_STATUS)
        next_rdata[3:0] = {lock, txState == ntl_pkg::TX_WAIT, txState != ntl_pkg::TX_IDLE, rxState != ntl_pkg::RX_IDLE};
      else if (s_axi_araddr[7:4] == ntl_pkg::OFS_TXD[7:4]) next_rdata = txData[{s_axi_araddr[3:2], 5'h00} +: 32];
      else if (s_axi_araddr[7:4] == ntl_pkg::OFS_RXD[7:4])
        next_rdata = 32'(rxData >> {s_axi_araddr[3:2], 5'h00});
      else next_rresp = ntl_pkg::RESP_DECERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    // hardware set wins over a software clear landing in the same cycle
    next_rxBusy = rxBusy;
    if (swFlags) next_rxBusy = wData[ntl_pkg::F_RXBUSY];
    if (rxRestore) next_rxBusy = rxSaved;
    if (rxSetBusy) next_rxBusy = 1'b1;
    next_txBusy = txBusy;
    next_lock = lock;
    if (txClr) next_txBusy = 1'b0;
    // a software request must never be lost to the first-character clear
    if (swFlags) begin
      next_txBusy = wData[ntl_pkg::F_TXBUSY];
      next_lock = 1'b0;
    end
    // a failure set wins over a software clear in the same cycle
    if (txFail) begin
      next_txBusy = 1'b1;
      next_lock = 1'b1;
    end
  end

  always_comb begin
    next_rxBit = rxBit;
    next_rxBaud = rxBaud;
    next_rxSh = rxSh;
    byteEv = 1'b0;
    frameErr = 1'b0;
    if (rxBit == 4'h0) begin
      if (!serialRx) begin
        next_rxBit = 4'h1;
        next_rxBaud = {1'b0, baud[15:1]};
      end
    end else if (rxBaud != 16'h0000) begin
      next_rxBaud = rxBaud - 16'h0001;
    end else begin
      next_rxBaud = baud;
      next_rxBit = rxBit + 4'h1;
      if (rxBit == 4'h1 && serialRx) next_rxBit = 4'h0;
      else if (rxBit >= 4'h2 && rxBit <= 4'h9) next_rxSh = {serialRx, rxSh[7:1]};
      else if (rxBit == 4'hA) begin
        next_rxBit = 4'h0;
        byteEv = 1'b1;
        frameErr = !serialRx;
      end
    end
    next_rxState = rxState;
    next_rxCnt = rxCnt;
    next_rxBcc = rxBcc;
    next_rxErr = rxErr;
    next_rxAcc = rxAcc;
    next_rxSaved = rxSaved;
    next_hashSeen = hashSeen;
    next_rxShadow = rxShadow;
    next_rxData = rxData;
    stxAcc = 1'b0;
    fin = 1'b0;
    ok = 1'b0;
    ackGood = 1'b0;
    ackBad = 1'b0;
    if (byteEv) begin
      unique case (rxState)
        ntl_pkg::RX_IDLE: begin
          next_hashSeen = rxSh == ntl_pkg::CH_HASH;
          if (rxSh == ntl_pkg::CH_STX && !frameErr) begin
            next_rxState = ntl_pkg::RX_DATA;
            next_rxCnt = 5'h00;
            next_rxBcc = 8'h00;
            next_rxErr = 1'b0;
            // stale digits of an earlier telegram must not show above n
            next_rxShadow = '0;
            next_rxSaved = rxBusy;
            next_rxAcc = rxAlw || !rxBusy;
            stxAcc = rxAlw || !rxBusy;
          end else if (bccOn) begin
            ackGood = rxSh == ntl_pkg::CH_ACK;
            ackBad = rxSh == ntl_pkg::CH_NAK;
          end else if (rxSh == ntl_pkg::CH_LF) begin
            ackGood = !hashSeen;
            ackBad = hashSeen;
          end
        end
        ntl_pkg::RX_DATA: begin
          next_rxBcc = rxBcc ^ rxSh;
          if (frameErr) next_rxErr = 1'b1;
          if (rxSh == ntl_pkg::CH_ETX) begin
            if (bccOn) next_rxState = ntl_pkg::RX_BCC;
            else begin
              fin = 1'b1;
              ok = !rxErr && !frameErr && rxCnt == nRx;
            end
          end else if (rxSh[7:4] != ntl_pkg::DIGIT_HI || rxCnt == 5'h1F) begin
            next_rxErr = 1'b1;
          end else begin
            next_rxShadow = {rxShadow[119:0], rxSh[3:0]};
            next_rxCnt = rxCnt + 5'h01;
          end
        end
        ntl_pkg::RX_BCC: begin
          fin = 1'b1;
          ok = !rxErr && !frameErr && rxCnt == nRx && rxSh == rxBcc;
        end
        default: next_rxState = ntl_pkg::RX_IDLE;
      endcase
    end
    store = fin && ok && rxAcc;
    if (fin) next_rxState = ntl_pkg::RX_IDLE;
    if (store) next_rxData = rxShadow;
    rxSetBusy = stxAcc || store;
    rxRestore = fin && !ok && rxAcc;
    ackReqEv = fin && retry != ntl_pkg::RETRY_RING;
  end

  always_comb begin
    tick = tickCnt >= 24'(((ctrl[ntl_pkg::C_FAST]) ? TICK_FAST : TICK_SLOW) - 1);
    next_tickCnt = tick ? 24'h00_0000 : tickCnt + 24'h00_0001;
    next_txState = txState;
    next_txPos = txPos;
    next_txBcc = txBcc;
    next_txRetry = txRetry;
    next_ackPend = ackPend;
    next_ackOk = ackOk;
    if (ackReqEv) begin
      next_ackPend = 1'b1;
      next_ackOk = ok;
    end
    txLoad = 1'b0;
    txClr = 1'b0;
    txFail = 1'b0;
    ch = ntl_pkg::CH_STX;
    last = 1'b0;
    if (txState == ntl_pkg::TX_TEL) begin
      if (txPos == 6'h00) ch = ntl_pkg::CH_STX;
      else if (txPos <= {1'b0, nTx}) ch = {ntl_pkg::DIGIT_HI, txData[{nTx - txPos[4:0], 2'b00} +: 4]};
      else if (txPos == {1'b0, nTx} + 6'h01) ch = ntl_pkg::CH_ETX;
      else ch = txBcc;
      last = txPos == {1'b0, nTx} + (bccOn ? 6'h02 : 6'h01);
    end else if (!bccOn) begin
      ch = (!ackOk && txPos == 6'h00) ? ntl_pkg::CH_HASH : ((txPos == (ackOk ? 6'h00 : 6'h01)) ? ntl_pkg::CH_CR : ntl_pkg::CH_LF);
      last = txPos == (ackOk ? 6'h01 : 6'h02);
    end else begin
      ch = ackOk ? ntl_pkg::CH_ACK : ntl_pkg::CH_NAK;
      last = 1'b1;
    end
    unique case (txState)
      ntl_pkg::TX_IDLE: begin
        next_txPos = 6'h00;
        next_txBcc = 8'h00;
        if (ackPend) begin
          next_ackPend = ackReqEv;
          next_txState = ntl_pkg::TX_ACK;
        end else if (tick && !lock && (txAlw || txBusy)) next_txState = ntl_pkg::TX_TEL;
      end
      ntl_pkg::TX_TEL, ntl_pkg::TX_ACK: begin
        if (txBit == 4'h0) begin
          txLoad = 1'b1;
          next_txPos = txPos + 6'h01;
          if (txPos != 6'h00) next_txBcc = txBcc ^ ch;
          if (txState == ntl_pkg::TX_TEL && txPos == 6'h00) txClr = 1'b1;
          if (last) begin
            next_txRetry = 5'h00;
            next_txState = ntl_pkg::TX_IDLE;
            if (txState == ntl_pkg::TX_TEL && !txAlw && retry != ntl_pkg::RETRY_RING) next_txState = ntl_pkg::TX_WAIT;
          end
        end
      end
      ntl_pkg::TX_WAIT: begin
        next_txPos = 6'h00;
        next_txBcc = 8'h00;
        if (ackGood) next_txState = ntl_pkg::TX_IDLE;
        else if (ackBad && retry == ntl_pkg::RETRY_ONCE) begin
          txFail = 1'b1;
          next_txState = ntl_pkg::TX_IDLE;
        end else if (tick) begin
          next_txRetry = txRetry + 5'h01;
          if (txRetry == ntl_pkg::RETRY_TICKS - 5'h01) begin
            next_txRetry = 5'h00;
            next_txState = ntl_pkg::TX_TEL;
            if (retry == ntl_pkg::RETRY_ONCE) begin
              txFail = 1'b1;
              next_txState = ntl_pkg::TX_IDLE;
            end
          end
        end
      end
    endcase
    next_txBit = txBit;
    next_txBaud = txBaud;
    next_txSh = txSh;
    next_serialTx = serialTx;
    if (txLoad) begin
      next_serialTx = 1'b0;
      next_txSh = {1'b1, ch};
      next_txBit = 4'hA;
      next_txBaud = baud;
    end else if (txBit != 4'h0) begin
      if (txBaud != 16'h0000) next_txBaud = txBaud - 16'h0001;
      else begin
        next_txBaud = baud;
        next_txBit = txBit - 4'h1;
        if (txBit > 4'h1) begin
          next_serialTx = txSh[0];
          next_txSh = {1'b1, txSh[8:1]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      {awHave, wHave, s_axi_bvalid, s_axi_rvalid, rxBusy, txBusy, lock} <= 7'h00;
      {s_axi_awready, s_axi_wready, s_axi_arready, serialTx} <= 4'hF;
      awAddr <= 8'h00;
      wData <= 32'h0000_0000;
      wStrb <= 4'h0;
      s_axi_bresp <= 2'h0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
      ctrl <= ntl_pkg::CTRL_RST;
      baud <= ntl_pkg::BAUD_RST;
      txData <= '0;
      rxState <= ntl_pkg::RX_IDLE;
      {rxBit, rxBaud, rxSh, rxBcc, rxCnt} <= '0;
      {rxErr, rxAcc, rxSaved, hashSeen} <= 4'h0;
      rxShadow <= '0;
      rxData <= '0;
      txState <= ntl_pkg::TX_IDLE;
      {txPos, txBcc, txRetry, tickCnt, txBit, txBaud} <= '0;
      txSh <= 9'h1FF;
      {ackPend, ackOk} <= 2'h0;
    end else begin
      {awHave, wHave, awAddr, wData, wStrb} <= {next_awHave, next_wHave, next_awAddr, next_wData, next_wStrb};
      {s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_bresp} <= {next_awready, next_wready, next_bvalid, next_bresp};
      {s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp} <= {next_arready, next_rvalid, next_rdata, next_rresp};
      {ctrl, baud, txData} <= {next_ctrl, next_baud, next_txData};
      {rxBusy, txBusy, lock} <= {next_rxBusy, next_txBusy, next_lock};
      rxState <= next_rxState;
      {rxBit, rxBaud, rxSh, rxBcc, rxCnt} <= {next_rxBit, next_rxBaud, next_rxSh, next_rxBcc, next_rxCnt};
      {rxErr, rxAcc, rxSaved, hashSeen} <= {next_rxErr, next_rxAcc, next_rxSaved, next_hashSeen};
      rxShadow <= next_rxShadow;
      rxData <= next_rxData;
      txState <= next_txState;
      {txPos, txBcc, txRetry, tickCnt} <= {next_txPos, next_txBcc, next_txRetry, next_tickCnt};
      {txBit, txBaud, txSh, serialTx} <= {next_txBit, next_txBaud, next_txSh, next_serialTx};
      {ackPend, ackOk} <= {next_ackPend, next_ackOk};
    end
  end

  rx_store_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    $changed(rxData) |-> $past(store)) else $error("receive buffer written without a good telegram");
  rx_shadow_copy_a: assert property (@(posedge sys_clk) disable iff (rst)
    store |=> rxData == $past(rxShadow)) else $error("receive buffer not copied from shadow");
  rx_always_acc_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteEv && rxState == ntl_pkg::RX_IDLE && rxSh == ntl_pkg::CH_STX && !frameErr && rxAlw |=> rxAcc)
    else $error("receive-always telegram not accepted");
  rx_single_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    fin && !rxAcc |=> $stable(rxData) ##1 $stable(rxData)) else $error("refused telegram overwrote buffer");
  rx_busy_early_a: assert property (@(posedge sys_clk) disable iff (rst)
    stxAcc |=> rxBusy && rxState == ntl_pkg::RX_DATA) else $error("receive busy late");
  tx_tick_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
    txState == ntl_pkg::TX_IDLE && next_txState == ntl_pkg::TX_TEL |-> tick) else $error("telegram started off tick");
  tx_busy_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    txLoad && txState == ntl_pkg::TX_TEL && txPos == 6'h00 && !swFlags |=> !txBusy && !serialTx)
    else $error("transmit busy not cleared at first character");
  tx_ring_nowait_a: assert property (@(posedge sys_clk) disable iff (rst)
    txState == ntl_pkg::TX_WAIT |-> retry != ntl_pkg::RETRY_RING) else $error("ring variant waits for ack");
  rx_bcc_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
    byteEv && rxState == ntl_pkg::RX_BCC && rxSh != rxBcc && !swFlags |=> $stable(rxData) && rxBusy == $past(rxSaved))
    else $error("bad check character accepted");
endmodule // ntl_link

// file: ntl_peer.sv
// Purpose: far-side serial peer of the numeric telegram link
// Assumes: 8N1 line, lsb first, bit period of BIT sys_clk cycles
// Notes: line idles high between frames, as a real peer does
`timescale 1ns/1ps
module ntl_peer #(
  parameter int BIT = 4
) (
  input wire logic sys_clk,
  input wire logic serialTx,
  output logic serialRx
);
  logic [7:0] got[$];
  logic [7:0] sh;
  initial serialRx = 1'b1;
  // start bit, eight data bits lsb first, stop bit
  task automatic sendByte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge sys_clk);
      serialRx <= fr[i];
      repeat (BIT - 1) @(posedge sys_clk);
    end
  endtask
  // mid-bit sampling; a glitch shorter than half a bit is not rejected
  initial begin
    forever begin
      @(negedge serialTx);
      repeat (BIT / 2) @(posedge sys_clk);
      for (int i = 0; i < 9; i++) begin
        repeat (BIT) @(posedge sys_clk);
        if (i < 8)
          sh[i] = serialTx;
      end
      got.push_back(sh);
    end
  end
endmodule // ntl_peer

// file: ntl_link_bench.sv
// Purpose: self-checking bench of the numeric telegram link
// Assumes: short ticks, bit period of four cycles
// Notes: expectations come from a small model of buffer and flags
`timescale 1ns/1ps
module ntl_link_bench;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic [7:0] s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, serialRx, serialTx;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rdData, rxWord;
  logic [7:0] lfsr = 8'h17;
  logic [7:0] txDig;
  int fail_count = 0, comparisons = 0, rxBusy;
  // both buffer sizes are always given, even when one side idles
  logic [31:0] cws[6] = '{32'h0000_1088, 32'h0000_1088, 32'h0000_1089, 32'h0000_1088, 32'h0000_1080, 32'h0000_1080};
  logic clrs[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
  logic [7:0] flips[6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h40};
  ntl_link #(.TICK_SLOW(200), .TICK_FAST(50)) ntl_link_i (.sys_clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .serialRx, .serialTx);
  ntl_peer #(.BIT(4)) ntl_peer_i (.sys_clk, .serialTx, .serialRx);
  initial forever #4 sys_clk = ~sys_clk;
  function automatic logic [7:0] nextRand();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction
  task end_of_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task hang();
    check(32'h0000_0000, 32'h0000_0001);
    end_of_test();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
      n++;
    end while (s_axi_bvalid !== 1'b1 && n < 50);
    s_axi_bready <= 1'b0;
    if (s_axi_bvalid !== 1'b1)
      hang();
    check(s_axi_bresp, ntl_pkg::RESP_OKAY);
  endtask
  task rd(input logic [7:0] a, input logic [1:0] resp);
    int n;
    n = 0;
    @(posedge sys_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
      n++;
    end while (s_axi_rvalid !== 1'b1 && n < 50);
    rdData = s_axi_rdata;
    s_axi_rready <= 1'b0;
    if (s_axi_rvalid !== 1'b1)
      hang();
    check(s_axi_rresp, resp);
  endtask
  // bounded wait so a silent line ends the run instead of hanging
  task checkByte(input logic [7:0] exp);
    int n;
    for (n = 0; ntl_peer_i.got.size() == 0; n++) begin
      if (n > 3000)
        hang();
      @(posedge sys_clk);
    end
    check(ntl_peer_i.got.pop_front(), exp);
  endtask
  task txCheck();
    checkByte({4'h3, txDig[7:4]});
    checkByte({4'h3, txDig[3:0]});
    checkByte(8'h03);
    checkByte({4'h0, txDig[7:4] ^ txDig[3:0]} ^ 8'h03);
  endtask
  task rxScen(input logic [31:0] cw, input logic clr, input logic [7:0] flip);
    logic [3:0] hi, lo;
    logic good;
    hi = 4'(nextRand());
    lo = 4'(nextRand());
    good = (flip == 8'h00);
    wr(ntl_pkg::OFS_CTRL, cw);
    if (clr) begin
      wr(ntl_pkg::OFS_FLAGS, 32'h0000_0000);
      rxBusy = 0;
    end
    ntl_peer_i.sendByte(8'h02);
    rd(ntl_pkg::OFS_FLAGS, ntl_pkg::RESP_OKAY);
    check(rdData[0], 1'b1);
    // sending the remaining characters before reading the buffer
    ntl_peer_i.sendByte({4'h3, hi});
    ntl_peer_i.sendByte({4'h3, lo} ^ flip);
    ntl_peer_i.sendByte(8'h03);
    if (cw[3])
      ntl_peer_i.sendByte({4'h0, hi ^ lo} ^ 8'h03);
    if (good && (cw[0] || rxBusy == 0)) begin
      rxWord = {24'h00_0000, hi, lo};
      rxBusy = 1;
    end
    if (cw[3])
      checkByte(good ? 8'h06 : 8'h15);
    else begin
      if (!good)
        checkByte(8'h23);
      checkByte(8'h0D);
      checkByte(8'h0A);
    end
    rd(ntl_pkg::OFS_RXD, ntl_pkg::RESP_OKAY);
    check(rdData, rxWord);
    rd(ntl_pkg::OFS_FLAGS, ntl_pkg::RESP_OKAY);
    check(rdData[0], rxBusy[0]);
  endtask
  initial begin
    rxWord = 32'h0000_0000;
    rxBusy = 0;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    wr(ntl_pkg::OFS_BAUD, 32'h0000_0003);
    rd(ntl_pkg::OFS_CTRL, ntl_pkg::RESP_OKAY);
    check(rdData, 32'h0000_0848);
    rd(ntl_pkg::OFS_FLAGS, ntl_pkg::RESP_OKAY);
    check(rdData, 32'h0000_0000);
    rd(8'h40, ntl_pkg::RESP_DECERR);
    check(rdData, 32'h0000_0000);
    txDig = nextRand();
    wr(ntl_pkg::OFS_CTRL, 32'h0000_10BC);
    wr(ntl_pkg::OFS_TXD, {24'h00_0000, txDig});
    wr(ntl_pkg::OFS_FLAGS, 32'h0000_0002);
    checkByte(8'h02);
    rd(ntl_pkg::OFS_FLAGS, ntl_pkg::RESP_OKAY);
    check(rdData[1], 1'b0);
    txCheck();
    // quiet window spans several ticks: a ring telegram goes out once
    repeat (1700) @(posedge sys_clk);
    check(ntl_peer_i.got.size(), 0);
    for (int i = 0; i < 6; i++)
      rxScen(cws[i], clrs[i], flips[i]);
    // option 1: a NAK leaves transmit busy high and locks further sends
    wr(ntl_pkg::OFS_CTRL, 32'h0000_109C);
    wr(ntl_pkg::OFS_FLAGS, 32'h0000_0002);
    checkByte(8'h02);
    txCheck();
    ntl_peer_i.sendByte(8'h15);
    rd(ntl_pkg::OFS_FLAGS, ntl_pkg::RESP_OKAY);
    check(rdData[1], 1'b1);
    rd(ntl_pkg::OFS_STATUS, ntl_pkg::RESP_OKAY);
    check(rdData[3], 1'b1);
    repeat (200) @(posedge sys_clk);
    check(ntl_peer_i.got.size(), 0);
    // option 0: silence brings a resend, an ACK ends the wait
    wr(ntl_pkg::OFS_CTRL, 32'h0000_108C);
    wr(ntl_pkg::OFS_FLAGS, 32'h0000_0002);
    for (int i = 0; i < 2; i++) begin
      checkByte(8'h02);
      txCheck();
    end
    ntl_peer_i.sendByte(8'h06);
    rd(ntl_pkg::OFS_STATUS, ntl_pkg::RESP_OKAY);
    check(rdData[2], 1'b0);
    wr(ntl_pkg::OFS_CTRL, 32'h0000_10BE);
    for (int i = 0; i < 2; i++) begin
      checkByte(8'h02);
      txCheck();
    end
    end_of_test();
  end
endmodule // ntl_link_bench
